//--- design/lbfs_supervisor.sv
// fault supervision and shutdown logic of the led boost driver
// Function
// - dim rising edge rechecks short-removed strings
// - output overvoltage low stops boost switching
// - open string at overvoltage is removed
// - switch node overvoltage latches device off
// - switch node latch clears only by shutdown
// - string detection completes before boost starts
// - cycle current limit ends current cycle
// - secondary limit shuts boost, sinks, gate
// - secondary limit latches until long dim-low
// - one-times current: bounded constant-current window
// - fault flag rises on entering one-times mode
// - one-times clears early: flag drops, normal
// - sync pin low long stops everything
// - long dim-low enters low power mode
// - two-times current turns disconnect gate off
// - two-times current latches shutdown with flag
// - dim low turns boost and sinks off
// - shorted sink pin string is removed
`timescale 1ns/1ns
`default_nettype none
module lbfs_supervisor #(
   parameter int P_DIM_LOW_CYCLES = 32750,
   parameter int P_CC_CYCLES      = 10000
) (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst,
   input  wire logic                    i_dim_enable,
   input  wire logic                    i_freq_set_sync_pin,
   input  wire logic                    i_undervoltage_lockout,
   input  wire lbfs_pkg::lbfs_cmp_t     i_cmp,
   output lbfs_pkg::lbfs_drv_t          o_drv,
   input  wire logic [3:0]              i_s_axi_awaddr,
   input  wire logic                    i_s_axi_awvalid,
   output logic                         o_s_axi_awready,
   input  wire logic [31:0]             i_s_axi_wdata,
   input  wire logic [3:0]              i_s_axi_wstrb,
   input  wire logic                    i_s_axi_wvalid,
   output logic                         o_s_axi_wready,
   output logic [1:0]                   o_s_axi_bresp,
   output logic                         o_s_axi_bvalid,
   input  wire logic                    i_s_axi_bready,
   input  wire logic [3:0]              i_s_axi_araddr,
   input  wire logic                    i_s_axi_arvalid,
   output logic                         o_s_axi_arready,
   output logic [31:0]                  o_s_axi_rdata,
   output logic [1:0]                   o_s_axi_rresp,
   output logic                         o_s_axi_rvalid,
   input  wire logic                    i_s_axi_rready
);
   import lbfs_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   localparam int SYNC_W = CMP_W + 3;

   logic [SYNC_W-1:0]      sync_out;
   lbfs_cmp_t              cmp_s;
   logic                   dim_s;
   logic                   fsync_s;
   logic                   lockout_s;
   logic                   dim_q;
   logic                   dim_rise;

   lbfs_sync #(.W(SYNC_W)) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_d       ({i_cmp, i_dim_enable, i_freq_set_sync_pin, i_undervoltage_lockout}),
      .o_q       (sync_out)
   );

   assign cmp_s   = sync_out[SYNC_W-1:3];
   assign dim_s   = sync_out[2];
   assign fsync_s = sync_out[1];
   assign lockout_s = sync_out[0];

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         dim_q <= 1'b0;
      else
         dim_q <= dim_s;
   end

   assign dim_rise = dim_s & ~dim_q;

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   logic [DIM_CNT_W-1:0]  dim_low_cnt;
   logic [SYNC_CNT_W-1:0] sync_low_cnt;
   logic [CC_CNT_W-1:0]   cc_cnt;
   logic [DET_CNT_W-1:0]  det_cnt;
   lbfs_state_t           state;
   logic                  active;
   logic                  shutdown_req;
   logic                  host_sd;
   logic                  cc_active;
   logic                  cc_expire;

   assign active = (state == LBFS_DETECT) || (state == LBFS_RUN);

   // dim low long enough, or supply lost: full shutdown
   assign shutdown_req = lockout_s
                       | (~dim_s && dim_low_cnt == DIM_CNT_W'(P_DIM_LOW_CYCLES - 1));

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         dim_low_cnt <= '0;
      else if (dim_s)
         dim_low_cnt <= '0;
      else if (dim_low_cnt != DIM_CNT_W'(P_DIM_LOW_CYCLES - 1))
         dim_low_cnt <= dim_low_cnt + 1'b1;
   end

   // sync pin low for longer than the host shutdown time
   assign host_sd = ~fsync_s && sync_low_cnt == SYNC_CNT_W'(SYNC_LOW_CYCLES);

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         sync_low_cnt <= '0;
      else if (fsync_s)
         sync_low_cnt <= '0;
      else if (sync_low_cnt != SYNC_CNT_W'(SYNC_LOW_CYCLES))
         sync_low_cnt <= sync_low_cnt + 1'b1;
   end

   // one-times constant-current window
   assign cc_active = active && cmp_s.input_current_1x && !cmp_s.input_current_2x;
   assign cc_expire = cc_active && cc_cnt == CC_CNT_W'(P_CC_CYCLES - 1);

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         cc_cnt <= '0;
      else if (cc_active)
         cc_cnt <= cc_cnt + 1'b1;
      else
         cc_cnt <= '0;
   end

   // ----------------------------------------------------------------
   // latched shutdown causes
   // ----------------------------------------------------------------
   logic [CAUSE_W-1:0] cause;
   logic [CAUSE_W-1:0] trip;
   logic               trip_now;

   always_comb
   begin
      trip                = '0;
      trip[CAUSE_NODE_OV] = (state == LBFS_RUN) && cmp_s.switch_node_overvoltage;
      trip[CAUSE_SEC_LIM] = cmp_s.secondary_switch_current_limit;
      trip[CAUSE_IN_2X]   = cmp_s.input_current_2x;
      trip[CAUSE_CC_EXP]  = cc_expire;
      trip[CAUSE_HOST]    = host_sd;
      if (!active)
         trip = '0;
   end

   assign trip_now = |trip;

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         cause <= '0;
      else if (shutdown_req)
         cause <= '0;
      else
         cause <= cause | trip;
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state   <= LBFS_SLEEP;
         det_cnt <= '0;
      end
      else if (shutdown_req)
      begin
         state   <= LBFS_SLEEP;
         det_cnt <= '0;
      end
      else
      begin
         unique case (state)
            LBFS_SLEEP:
            begin
               det_cnt <= '0;
               if (dim_s)
                  state <= LBFS_DETECT;
            end
            LBFS_DETECT:
            begin
               det_cnt <= det_cnt + 1'b1;
               if (trip_now)
                  state <= LBFS_LATCHED;
               else if (det_cnt == DET_CNT_W'(DETECT_CYCLES - 1))
                  state <= LBFS_RUN;
            end
            LBFS_RUN:
            begin
               if (trip_now)
                  state <= LBFS_LATCHED;
            end
            LBFS_LATCHED:
               state <= LBFS_LATCHED;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // string removal
   // ----------------------------------------------------------------
   logic [NUM_STRINGS-1:0] short_rm;
   logic [NUM_STRINGS-1:0] open_rm;
   logic [NUM_STRINGS-1:0] str_en;
   logic                   overvoltage_hit;
   logic                   sinking;

   assign overvoltage_hit = ~cmp_s.output_overvoltage_sense_n;
   assign sinking = active && dim_s;

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         short_rm <= '0;
      else if (state == LBFS_SLEEP)
         short_rm <= '0;
      else
         short_rm <= (dim_rise ? '0 : short_rm)
                   | (sinking ? cmp_s.led_sink_pin_short : '0);
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         open_rm <= '0;
      else if (state == LBFS_SLEEP)
         open_rm <= '0;
      else if (state == LBFS_RUN && overvoltage_hit)
         open_rm <= open_rm | cmp_s.led_open;
   end

   // ----------------------------------------------------------------
   // power stage drive
   // ----------------------------------------------------------------
   lbfs_drv_t next_drv;
   logic      run_ok;

   assign run_ok = (state == LBFS_RUN) && !trip_now;

   always_comb
   begin
      next_drv                 = '0;
      next_drv.boost_enable    = run_ok && dim_s
                               && !overvoltage_hit
                               && !cmp_s.cycle_current_limit;
      next_drv.disconnect_gate = active && !trip_now;
      next_drv.disconnect_cc   = cc_active && !trip_now;
      if (state == LBFS_DETECT && dim_s && !trip_now)
         next_drv.led_sink_enable = str_en & ~short_rm;
      else if (run_ok && dim_s)
         next_drv.led_sink_enable = str_en & ~short_rm & ~open_rm;
      next_drv.fault = cc_active
                     | (|((cause | trip) & CAUSE_FLAG_MASK));
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         o_drv <= '0;
      else
         o_drv <= next_drv;
   end

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   logic [31:0] status;

   always_comb
   begin
      status = '0;
      status[ST_SHORT_LSB +: NUM_STRINGS] = short_rm;
      status[ST_OPEN_LSB +: NUM_STRINGS]  = open_rm;
      status[ST_CAUSE_LSB +: CAUSE_W]     = cause;
      status[ST_FAULT_BIT]                = o_drv.fault;
      status[ST_STATE_LSB +: 2]           = state;
      status[ST_CC_BIT]                   = cc_active;
   end

   // write channel: both address and data taken together
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready  <= 1'b0;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= RESP_OKAY;
         str_en          <= CTRL_RESET;
      end
      else
      begin
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready  <= 1'b0;
         if (o_s_axi_bvalid && i_s_axi_bready)
            o_s_axi_bvalid <= 1'b0;
         if (i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid
             && !o_s_axi_awready)
         begin
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready  <= 1'b1;
            o_s_axi_bvalid  <= 1'b1;
            if (i_s_axi_awaddr == ADDR_CTRL)
            begin
               o_s_axi_bresp <= RESP_OKAY;
               if (i_s_axi_wstrb[0])
                  str_en <= i_s_axi_wdata[NUM_STRINGS-1:0];
            end
            else if (i_s_axi_awaddr == ADDR_STATUS)
               o_s_axi_bresp <= RESP_OKAY;
            else
               o_s_axi_bresp <= RESP_DECERR;
         end
      end
   end

   // read channel
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= '0;
         o_s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         o_s_axi_arready <= 1'b0;
         if (o_s_axi_rvalid && i_s_axi_rready)
            o_s_axi_rvalid <= 1'b0;
         if (i_s_axi_arvalid && !o_s_axi_rvalid && !o_s_axi_arready)
         begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid  <= 1'b1;
            o_s_axi_rresp   <= RESP_OKAY;
            if (i_s_axi_araddr == ADDR_CTRL)
               o_s_axi_rdata <= {{(32-NUM_STRINGS){1'b0}}, str_en};
            else if (i_s_axi_araddr == ADDR_STATUS)
               o_s_axi_rdata <= status;
            else
            begin
               o_s_axi_rdata <= '0;
               o_s_axi_rresp <= RESP_DECERR;
            end
         end
      end
   end

endmodule
`default_nettype wire

//--- design/lbfs_pkg.sv
// shared constants and types for the led boost fault supervisor
package lbfs_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 100;
   localparam int SYNC_LOW_NS      = 7000;
   localparam int SYNC_LOW_CYCLES  = (SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIM_LOW_CYCLES   = 32750;
   localparam int CC_WINDOW_CYCLES = 10000;
   localparam int DETECT_CYCLES    = 16;
   localparam int SYNC_CNT_W       = 8;
   localparam int DIM_CNT_W        = 16;
   localparam int CC_CNT_W         = 16;
   localparam int DET_CNT_W        = 5;

   // ----------------------------------------------------------------
   // strings and register map
   // ----------------------------------------------------------------
   localparam int NUM_STRINGS = 4;
   localparam int AXI_AW      = 4;
   localparam logic [AXI_AW-1:0] ADDR_CTRL   = 4'h0;
   localparam logic [AXI_AW-1:0] ADDR_STATUS = 4'h4;
   localparam logic [NUM_STRINGS-1:0] CTRL_RESET = 4'hf;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // status field positions
   localparam int ST_SHORT_LSB = 0;
   localparam int ST_OPEN_LSB  = 4;
   localparam int ST_CAUSE_LSB = 8;
   localparam int ST_FAULT_BIT = 13;
   localparam int ST_STATE_LSB = 14;
   localparam int ST_CC_BIT    = 16;

   // latched shutdown causes
   localparam int CAUSE_W       = 5;
   localparam int CAUSE_NODE_OV = 0;
   localparam int CAUSE_SEC_LIM = 1;
   localparam int CAUSE_IN_2X   = 2;
   localparam int CAUSE_CC_EXP  = 3;
   localparam int CAUSE_HOST    = 4;
   localparam logic [CAUSE_W-1:0] CAUSE_FLAG_MASK = 5'h0f;

   typedef enum logic [1:0] {
      LBFS_SLEEP,
      LBFS_DETECT,
      LBFS_RUN,
      LBFS_LATCHED
   } lbfs_state_t;

   // comparator outputs from the analog side
   typedef struct packed {
      logic                   output_overvoltage_sense_n;
      logic                   switch_node_overvoltage;
      logic                   cycle_current_limit;
      logic                   secondary_switch_current_limit;
      logic                   input_current_1x;
      logic                   input_current_2x;
      logic [NUM_STRINGS-1:0] led_open;
      logic [NUM_STRINGS-1:0] led_sink_pin_short;
   } lbfs_cmp_t;

   localparam int CMP_W = $bits(lbfs_cmp_t);

   // drive to the power stage
   typedef struct packed {
      logic                   boost_enable;
      logic                   disconnect_gate;
      logic                   disconnect_cc;
      logic [NUM_STRINGS-1:0] led_sink_enable;
      logic                   fault;
   } lbfs_drv_t;

endpackage

//--- design/lbfs_sync.sv
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module lbfs_sync #(
   parameter int W = 1
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] meta;

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta <= '0;
         o_q  <= '0;
      end
      else
      begin
         meta <= i_d;
         o_q  <= meta;
      end
   end

endmodule
`default_nettype wire

//--- testbench/lbfs_supervisor_monitor.sv
// assertion checker for the led boost fault supervisor
`timescale 1ns/1ns
`default_nettype none
module lbfs_supervisor_monitor #(
   parameter int P_DIM_LOW_CYCLES = 32750,
   parameter int P_CC_CYCLES      = 10000
) (
   input wire logic                i_ref_clk,
   input wire logic                i_rst,
   input wire logic                i_dim_enable,
   input wire logic                i_freq_set_sync_pin,
   input wire logic                i_undervoltage_lockout,
   input wire lbfs_pkg::lbfs_cmp_t i_cmp,
   input wire lbfs_pkg::lbfs_drv_t o_drv
);
   import lbfs_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   int dim_lo;
   int sync_lo;
   int cc_on;
   // run lengths of dim low, sync low and constant-current mode
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
      begin
         dim_lo  <= 0;
         sync_lo <= 0;
         cc_on   <= 0;
      end
      else
      begin
         dim_lo  <= i_dim_enable ? 0 : dim_lo + 1;
         sync_lo <= i_freq_set_sync_pin ? 0 : sync_lo + 1;
         cc_on   <= o_drv.disconnect_cc ? cc_on + 1 : 0;
      end
   sequence s_overvoltage_held;
      !i_cmp.output_overvoltage_sense_n [*4];
   endsequence
   sequence s_cyc_held;
      i_cmp.cycle_current_limit [*4];
   endsequence
   sequence s_latched;
      o_drv == 8'h01;
   endsequence
   AST_OVERVOLTAGE_STOP: assert property (s_overvoltage_held |-> !o_drv.boost_enable)
      else $error("boost running under output overvoltage");
   AST_CYC_STOP: assert property (s_cyc_held |-> !o_drv.boost_enable)
      else $error("boost running at cycle current limit");
   AST_DIM_OFF: assert property ((!i_dim_enable) [*4] |->
      !o_drv.boost_enable && o_drv.led_sink_enable == 4'h0)
      else $error("boost or sinks on while dim low");
   AST_DETECT_FIRST: assert property ($rose(o_drv.boost_enable) |->
      $past(o_drv.disconnect_gate, 8))
      else $error("boost started without detection phase");
   AST_NODE_OVERVOLTAGE: assert property (i_cmp.switch_node_overvoltage && o_drv.boost_enable
      && !i_undervoltage_lockout |-> ##[1:3] s_latched)
      else $error("switch node overvoltage not latched");
   AST_SEC_LIM: assert property ($rose(i_cmp.secondary_switch_current_limit)
      && o_drv.disconnect_gate |-> ##[1:3] s_latched)
      else $error("secondary limit not latched");
   AST_IN_2X: assert property ($rose(i_cmp.input_current_2x) && o_drv.disconnect_gate
      |-> ##[1:3] s_latched)
      else $error("two-times current not latched");
   AST_CC_FLAG: assert property ($rose(i_cmp.input_current_1x) &&
      !i_cmp.input_current_2x && o_drv.boost_enable |-> ##[1:3]
      (o_drv.fault && o_drv.disconnect_cc))
      else $error("one-times mode without flag");
   AST_CC_BOUND: assert property (cc_on <= P_CC_CYCLES + 3)
      else $error("constant-current window too long");
   AST_SYNC_STOP: assert property (sync_lo >= SYNC_LOW_CYCLES + 5 |-> o_drv == 8'h00)
      else $error("drive on after long sync low");
   AST_DIM_SLEEP: assert property (dim_lo >= P_DIM_LOW_CYCLES + 5 |-> o_drv == 8'h00)
      else $error("drive on after long dim low");
endmodule
`default_nettype wire

//--- testbench/lbfs_host_model.sv
// host model driving the dim/enable and sync pins
`timescale 1ns/1ns
`default_nettype none
module lbfs_host_model #(
   parameter int P_HALT_CYCLES = lbfs_pkg::SYNC_LOW_CYCLES + 20
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_dim_req,
   input  wire logic i_halt_req,
   output logic      o_dim_enable,
   output logic      o_freq_set_sync_pin
);
   int halt_cnt;
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
         o_dim_enable <= 1'b0;
      else
         o_dim_enable <= i_dim_req;
   // sync pin held low well past the shutdown time
   always_ff @(posedge i_ref_clk or posedge i_rst)
      if (i_rst)
         halt_cnt <= 0;
      else if (i_halt_req && halt_cnt == 0)
         halt_cnt <= P_HALT_CYCLES;
      else if (halt_cnt != 0)
         halt_cnt <= halt_cnt - 1;
   assign o_freq_set_sync_pin = (halt_cnt == 0);
endmodule
`default_nettype wire

//--- testbench/tb_lbfs_supervisor.sv
// self-checking testbench for the led boost fault supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_lbfs_supervisor;
   import lbfs_pkg::*;
   localparam int        P_DIM = 40;
   localparam int        P_CC  = 20;
   localparam lbfs_cmp_t IDLE  = lbfs_cmp_t'(14'h2000);
   logic i_ref_clk = 1'b0, i_rst = 1'b1, dim_req = 1'b0, halt_req = 1'b0, lockout = 1'b0;
   logic dim, sync_pin, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   lbfs_cmp_t   cmp = IDLE;
   lbfs_drv_t   drv;
   int n_fail = 0, n_tests = 0, cycles = 0;

   always #50 i_ref_clk = ~i_ref_clk;

   lbfs_host_model i_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_dim_req(dim_req),
      .i_halt_req(halt_req), .o_dim_enable(dim), .o_freq_set_sync_pin(sync_pin));
   lbfs_supervisor #(.P_DIM_LOW_CYCLES(P_DIM), .P_CC_CYCLES(P_CC)) i_dut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_dim_enable(dim),
      .i_freq_set_sync_pin(sync_pin), .i_undervoltage_lockout(lockout), .i_cmp(cmp),
      .o_drv(drv), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic chk_drv(input lbfs_drv_t exp);
      n_tests++;
      if (drv !== exp)
      begin
         n_fail++;
         $display("wrong value o_drv expected %h seen %h", exp, drv);
      end
   endtask
   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge i_ref_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a);
      @(posedge i_ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge i_ref_clk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic pulse_cmp(input lbfs_cmp_t c, input lbfs_drv_t on, input lbfs_drv_t off);
      cmp <= c;
      step(6);
      chk_drv(on);
      cmp <= IDLE;
      step(6);
      chk_drv(off);
   endtask
   task automatic wake;
      dim_req <= 1'b1;
      step(30);
      chk_drv(8'hde);
   endtask
   task automatic to_sleep;
      dim_req <= 1'b0;
      step(P_DIM + 10);
      chk_drv(8'h00);
   endtask

   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_fail++;
         end_sim();
      end
   end

   initial
   begin
      step(10);
      i_rst <= 1'b0;
      step(1);
      chk_drv(8'h00);
      axi_rd(ADDR_CTRL);
      chk_word("ctrl", {28'h0, CTRL_RESET}, rd);
      axi_rd(4'h8);
      chk_word("unmapped read", {30'h0, RESP_DECERR}, {30'h0, rs});
      chk_word("unmapped data", 32'h0, rd);
      axi_wr(ADDR_STATUS, 32'hffff_ffff);
      chk_word("status write", {30'h0, RESP_OKAY}, {30'h0, rs});
      axi_wr(4'hc, 32'h0);
      chk_word("unmapped write", {30'h0, RESP_DECERR}, {30'h0, rs});
      dim_req <= 1'b1;
      step(10);
      chk_drv(8'h5e);
      wake();
      axi_wr(ADDR_CTRL, 32'h3);
      step(3);
      chk_drv(8'hc6);
      axi_wr(ADDR_CTRL, 32'hf);
      step(3);
      pulse_cmp(14'h0000, 8'h5e, 8'hde);
      pulse_cmp(14'h2800, 8'h5e, 8'hde);
      pulse_cmp(14'h0010, 8'h5c, 8'hdc);
      pulse_cmp(14'h2002, 8'hd8, 8'hd8);
      axi_rd(ADDR_STATUS);
      chk_word("status", 32'h0000_8012, rd);
      dim_req <= 1'b0;
      step(6);
      chk_drv(8'h40);
      dim_req <= 1'b1;
      step(6);
      chk_drv(8'hdc);
      pulse_cmp(14'h2200, 8'hfd, 8'hdc);
      cmp <= 14'h2200;
      step(P_CC + 10);
      chk_drv(8'h01);
      cmp <= IDLE;
      to_sleep();
      wake();
      for (int i = 0; i < 3; i++)
      begin
         cmp <= IDLE | (14'h1000 >> (2 * i));
         step(6);
         chk_drv(8'h01);
         cmp <= IDLE;
         dim_req <= 1'b0;
         step(6);
         dim_req <= 1'b1;
         step(10);
         chk_drv(8'h01);
         if (i == 0)
         begin
            lockout <= 1'b1;
            step(6);
            chk_drv(8'h00);
            lockout <= 1'b0;
         end
         else
            to_sleep();
         wake();
      end
      halt_req <= 1'b1;
      step(1);
      halt_req <= 1'b0;
      step(85);
      chk_drv(8'h00);
      to_sleep();
      wake();
      end_sim();
   end
endmodule

bind lbfs_supervisor lbfs_supervisor_monitor #(.P_DIM_LOW_CYCLES(P_DIM_LOW_CYCLES),
   .P_CC_CYCLES(P_CC_CYCLES)) i_mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .i_dim_enable(i_dim_enable), .i_freq_set_sync_pin(i_freq_set_sync_pin),
   .i_undervoltage_lockout(i_undervoltage_lockout), .i_cmp(i_cmp), .o_drv(o_drv));
`default_nettype wire
